// File: src/asp_axis_ctrl.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module asp_axis_ctrl
  import asp_pkg::*;
#(
  parameter int TICK_CYC = ASP_TICK_CYC
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Digital inputs.
  input  wire logic        enable_in,
  input  wire logic        start_in,
  input  wire logic        sync_select_pin,
  input  wire logic        sensor_error,
  // Analog values, already converted, unsigned positions and speed demand.
  input  wire logic [15:0] command_pos,
  input  wire logic [15:0] speed_demand,
  input  wire logic [15:0] actual_pos,
  input  wire logic [15:0] master_pos,
  // Outputs.
  output logic             ready_out,
  output logic             status_out,
  output logic signed [15:0] valve_out
);

  // Configuration registers.
  logic [4:0]  ctrl;
  logic [15:0] brake_dist;
  logic [15:0] internal_speed_limit;
  logic [15:0] in_position_window;
  logic [15:0] emergency_output_value;
  logic [15:0] emerg_stroke;
  logic [15:0] deadband;

  // Control state.
  asp_state_t  state;
  asp_state_t  next_state;
  logic [16:0] tick_cnt;
  logic        tick;
  logic        enable_q;
  logic        start_q;
  logic [15:0] target;
  logic [15:0] profile;
  logic [15:0] next_target;
  logic [15:0] next_profile;
  logic [15:0] gain;
  logic signed [15:0] next_out;
  logic        next_status;

  // Register decode.
  wire logic        apb_wr     = psel & penable & pwrite;
  wire logic        sel_ctrl   = (paddr == ASP_OFS_CTRL);
  wire logic        sel_brake  = (paddr == ASP_OFS_BRAKE);
  wire logic        sel_speed  = (paddr == ASP_OFS_SPEED);
  wire logic        sel_in_position_window  = (paddr == ASP_OFS_IN_POSITION_WINDOW);
  wire logic        sel_emergency_output_value   = (paddr == ASP_OFS_EMERGENCY_OUTPUT_VALUE);
  wire logic        sel_estr   = (paddr == ASP_OFS_ESTROKE);
  wire logic        sel_deadb  = (paddr == ASP_OFS_DEADB);
  wire logic        sel_state  = (paddr == ASP_OFS_STATE);
  wire logic        sel_target = (paddr == ASP_OFS_TARGET);
  wire logic        sel_output = (paddr == ASP_OFS_OUTPUT);
  wire logic        mapped     = sel_ctrl | sel_brake | sel_speed | sel_in_position_window | sel_emergency_output_value | sel_estr
                                 | sel_deadb | sel_state | sel_target | sel_output;

  // Configuration fields.
  wire logic        decel_mode = ctrl[ASP_CTRL_MODE];
  wire asp_curve_t  curve      = asp_curve_t'(ctrl[ASP_CTRL_CURVE +: 2]);
  wire logic        speed_ext  = ctrl[ASP_CTRL_VSRC];
  wire logic        emerg_en   = ctrl[ASP_CTRL_EMEN];

  // The slave registers answer at once; pready never stretches an access.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read mux, unmapped addresses read zero.
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (sel_ctrl)   prdata = {27'h0, ctrl};
    if (sel_brake)  prdata = {16'h0, brake_dist};
    if (sel_speed)  prdata = {16'h0, internal_speed_limit};
    if (sel_in_position_window)  prdata = {16'h0, in_position_window};
    if (sel_emergency_output_value)   prdata = {16'h0, emergency_output_value};
    if (sel_estr)   prdata = {16'h0, emerg_stroke};
    if (sel_deadb)  prdata = {16'h0, deadband};
    if (sel_state)  prdata = {26'h0, sync_select_pin, state, status_out, ready_out, tick};
    if (sel_target) prdata = {profile, target};
    if (sel_output) prdata = {16'h0, valve_out};
  end

  // Register writes take effect at the completing APB edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl                   <= ASP_RST_CTRL;
      brake_dist             <= ASP_RST_BRAKE;
      internal_speed_limit   <= ASP_RST_SPEED;
      in_position_window     <= ASP_RST_IN_POSITION_WINDOW;
      emergency_output_value <= ASP_RST_EMERGENCY_OUTPUT_VALUE;
      emerg_stroke           <= ASP_RST_ESTROKE;
      deadband               <= ASP_RST_DEADB;
    end
    else if (apb_wr)
    begin
      if (sel_ctrl)  ctrl                   <= pwdata[4:0];
      if (sel_brake) brake_dist             <= pwdata[15:0];
      if (sel_speed) internal_speed_limit   <= pwdata[15:0];
      if (sel_in_position_window) in_position_window     <= pwdata[15:0];
      if (sel_emergency_output_value)  emergency_output_value <= pwdata[15:0];
      if (sel_estr)  emerg_stroke           <= pwdata[15:0];
      if (sel_deadb) deadband               <= pwdata[15:0];
    end
  end

  // Sample tick divider: one pulse per 1 ms.
  assign tick = (tick_cnt == 17'(TICK_CYC - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= 17'h00000;
    else if (tick)
      tick_cnt <= 17'h00000;
    else
      tick_cnt <= tick_cnt + 17'h00001;
  end

  // Integer square root, restoring method on a 32-bit radicand.
  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [31:0] rem;
    logic [15:0] root;
    logic [17:0] trial;
    rem  = 32'h0;
    root = 16'h0;
    for (int i = 15; i >= 0; i--)
    begin
      rem   = {rem[29:0], x[2*i+1], x[2*i]};
      trial = {root, 2'b01};
      if (rem >= {14'h0, trial})
      begin
        rem  = rem - {14'h0, trial};
        root = {root[14:0], 1'b1};
      end
      else
        root = {root[14:0], 1'b0};
    end
    return root;
  endfunction

  // Gain from curve and braking distance; a zero distance is treated as one.
  wire logic [15:0] dist_safe = (brake_dist == 16'h0) ? 16'h0001 : brake_dist;
  wire logic [31:0] curve_num = (curve == ASP_CURVE_ROOT2) ? ASP_NUM_ROOT2 :
                                (curve == ASP_CURVE_ROOT1) ? ASP_NUM_ROOT1 :
                                ASP_NUM_LIN;
  wire logic [31:0] gain_full = curve_num / {16'h0, dist_safe};

  // Sync is active whenever this card's select is high; a master has it low.
  wire logic        sync_on   = sync_select_pin;

  // Reference: the partner or master axis position overrides the own target.
  wire logic [15:0] pos_ref   = sync_on ? master_pos : (decel_mode ? target : profile);
  wire logic signed [16:0] err = $signed({1'b0, pos_ref}) - $signed({1'b0, actual_pos});
  wire logic [15:0] err_mag   = err[16] ? 16'(-err) : err[15:0];

  // Remaining stroke shaped by the curve: linear or root of the distance left.
  wire logic [15:0] root_mag  = isqrt({err_mag, 16'h0000});
  wire logic [31:0] lin_prod  = {16'h0, err_mag} * {16'h0, gain};
  wire logic [31:0] root_prod = {16'h0, root_mag} * {16'h0, gain};
  wire logic [31:0] drive_raw = (curve == ASP_CURVE_LIN) ? (lin_prod >> 8) : (root_prod >> 16);
  wire logic [15:0] drive_mag = (drive_raw > 32'h0000_7FFF) ? 16'h7FFF : drive_raw[15:0];

  // Double gain below the deadband value, then offset by it; no step at zero.
  wire logic [16:0] dbl_mag   = {drive_mag, 1'b0};
  wire logic [16:0] ofs_mag   = {1'b0, drive_mag} + {1'b0, deadband};
  wire logic [16:0] shp_mag   = (drive_mag < deadband) ? dbl_mag : ofs_mag;

  // Speed limit from the register or the external demand.
  wire logic [15:0] speed_lim = speed_ext ? speed_demand : internal_speed_limit;
  wire logic [15:0] lim_sel   = (speed_lim > 16'h7FFF) ? 16'h7FFF : speed_lim;
  wire logic [15:0] out_mag   = (shp_mag > {1'b0, lim_sel}) ? lim_sel : shp_mag[15:0];
  wire logic signed [15:0] ctrl_out = err[16] ? -$signed(out_mag) : $signed(out_mag);

  // Window check against the loop error in either mode.
  wire logic        in_window = (err_mag <= in_position_window);

  // Failure conditions for the emergency output.
  wire logic        fault     = sensor_error | ~enable_in;
  wire logic        ready_now = enable_in & ~sensor_error;

  // Edges of enable and start as seen at the tick.
  wire logic        enable_rise = enable_in & ~enable_q;
  wire logic        start_rise  = start_in & ~start_q;
  wire logic        start_fall  = ~start_in & start_q;

  // Profile step toward target, bounded by the speed limit per sample.
  wire logic [15:0] prof_gap  = (target > profile) ? (target - profile) : (profile - target);
  wire logic [15:0] prof_step = (prof_gap > lim_sel) ? lim_sel : prof_gap;
  wire logic [15:0] prof_next = (target > profile) ? (profile + prof_step) : (profile - prof_step);

  // Emergency deceleration target, moved in the direction of travel and saturated.
  wire logic [16:0] stop_up   = {1'b0, actual_pos} + {1'b0, emerg_stroke};
  wire logic [15:0] stop_dn   = (actual_pos > emerg_stroke) ? (actual_pos - emerg_stroke) : 16'h0000;
  wire logic [15:0] stop_pos  = err[16] ? stop_dn : (stop_up[16] ? 16'hFFFF : stop_up[15:0]);

  // Sequencing by the digital inputs.
  always_comb
  begin
    next_state   = state;
    next_target  = target;
    next_profile = decel_mode ? target : prof_next;
    if (!ready_now)
    begin
      next_state   = ASP_ST_OFF;
      next_profile = actual_pos;
    end
    else
    begin
      unique case (state)
        ASP_ST_OFF:
        begin
          next_state   = ASP_ST_HOLD;
          next_target  = actual_pos;
          next_profile = actual_pos;
        end
        ASP_ST_HOLD:
        begin
          if (start_in)
          begin
            next_state  = ASP_ST_RUN;
            next_target = command_pos;
          end
        end
        ASP_ST_RUN:
        begin
          if (start_fall)
          begin
            next_state   = ASP_ST_STOP;
            next_target  = in_window ? target : stop_pos;
            next_profile = in_window ? target : stop_pos;
          end
          else
            next_target = command_pos;
        end
        ASP_ST_STOP:
        begin
          if (start_rise)
          begin
            next_state  = ASP_ST_RUN;
            next_target = command_pos;
          end
        end
      endcase
    end
  end

  // Output selection: emergency value, zero, or the loop output.
  always_comb
  begin
    if (fault)
      next_out = emerg_en ? $signed(emergency_output_value) : 16'sh0000;
    else
      next_out = ctrl_out;
    next_status = start_in & ready_now & in_window;
  end

  // All loop state moves once per sample tick.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ASP_ST_OFF;
      enable_q   <= 1'b0;
      start_q    <= 1'b0;
      target     <= 16'h0000;
      profile    <= 16'h0000;
      gain       <= 16'h0000;
      valve_out  <= 16'sh0000;
      ready_out  <= 1'b0;
      status_out <= 1'b0;
    end
    else if (tick)
    begin
      state      <= next_state;
      enable_q   <= enable_in;
      start_q    <= start_in;
      target     <= next_target;
      profile    <= next_profile;
      gain       <= gain_full[15:0];
      valve_out  <= next_out;
      ready_out  <= ready_now;
      status_out <= next_status;
    end
  end

  // Enable edge is tracked for software view only through state; keep it observable.
  wire logic unused_ok = enable_rise;

endmodule

`default_nettype wire

// File: common/asp_pkg.sv
package asp_pkg;

  // APB register byte offsets.
  localparam logic [7:0] ASP_OFS_CTRL    = 8'h00;
  localparam logic [7:0] ASP_OFS_BRAKE   = 8'h04;
  localparam logic [7:0] ASP_OFS_SPEED   = 8'h08;
  localparam logic [7:0] ASP_OFS_IN_POSITION_WINDOW   = 8'h0C;
  localparam logic [7:0] ASP_OFS_EMERGENCY_OUTPUT_VALUE    = 8'h10;
  localparam logic [7:0] ASP_OFS_ESTROKE = 8'h14;
  localparam logic [7:0] ASP_OFS_DEADB   = 8'h18;
  localparam logic [7:0] ASP_OFS_STATE   = 8'h1C;
  localparam logic [7:0] ASP_OFS_TARGET  = 8'h20;
  localparam logic [7:0] ASP_OFS_OUTPUT  = 8'h24;

  // Control register field positions.
  localparam int ASP_CTRL_MODE   = 0;
  localparam int ASP_CTRL_CURVE  = 1;
  localparam int ASP_CTRL_VSRC   = 3;
  localparam int ASP_CTRL_EMEN   = 4;

  // Reset values.
  localparam logic [4:0]  ASP_RST_CTRL    = 5'h10;
  localparam logic [15:0] ASP_RST_BRAKE   = 16'h03E8;
  localparam logic [15:0] ASP_RST_SPEED   = 16'h7FFF;
  localparam logic [15:0] ASP_RST_IN_POSITION_WINDOW   = 16'h0010;
  localparam logic [15:0] ASP_RST_EMERGENCY_OUTPUT_VALUE    = 16'h0000;
  localparam logic [15:0] ASP_RST_ESTROKE = 16'h0020;
  localparam logic [15:0] ASP_RST_DEADB   = 16'h0000;

  // Braking curve numerators.
  localparam logic [31:0] ASP_NUM_LIN   = 32'h0000_2710;
  localparam logic [31:0] ASP_NUM_ROOT1 = 32'h0000_7530;
  localparam logic [31:0] ASP_NUM_ROOT2 = 32'h0000_C350;

  // Sample period and clock.
  localparam int ASP_SAMPLE_NS = 1000000;
  localparam int ASP_CLK_NS    = 8;
  localparam int ASP_TICK_CYC  = ASP_SAMPLE_NS / ASP_CLK_NS;

  typedef enum logic [1:0]
  {
    ASP_CURVE_LIN   = 2'b00,
    ASP_CURVE_ROOT1 = 2'b01,
    ASP_CURVE_ROOT2 = 2'b10
  } asp_curve_t;

  typedef enum logic [1:0]
  {
    ASP_ST_OFF  = 2'b00,
    ASP_ST_HOLD = 2'b01,
    ASP_ST_RUN  = 2'b10,
    ASP_ST_STOP = 2'b11
  } asp_state_t;

endpackage

// File: testbench/asp_axis_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module asp_axis_ctrl_chk
  import asp_pkg::*;
#(
  parameter int TICK_CYC = ASP_TICK_CYC
)
(
  // Clock, reset and bus answer.
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Control pins.
  input wire logic               enable_in,
  input wire logic               start_in,
  input wire logic               sensor_error,
  input wire logic               ready_out,
  input wire logic               status_out,
  input wire logic signed [15:0] valve_out
);
  logic [31:0] cnt;
  wire         tick = (cnt == TICK_CYC - 1);
  wire         hole = psel && penable && (paddr > 8'h24);

  // Private copy of the sample counter, since no tick pin leaves the block.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt <= 32'h0;
    else
      cnt <= tick ? 32'h0 : cnt + 32'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_ready_follow: assert property (tick |=> ready_out == $past(enable_in && !sensor_error))
    else $error("ready disagrees with enable");
  chk_ready_steady: assert property ($changed(ready_out) |=> $stable(ready_out) [*8])
    else $error("ready moved between samples");
  chk_valve_tick: assert property (!tick |=> $stable(valve_out))
    else $error("drive moved off tick");
  chk_status_tick: assert property (!tick |=> $stable(status_out))
    else $error("status moved off tick");
  chk_status_start: assert property (tick && !start_in |=> !status_out)
    else $error("status without start");
  chk_fault_drop: assert property (tick && sensor_error |=> !ready_out && !status_out)
    else $error("flags kept on sensor fault");
  chk_enable_drop: assert property (tick && !enable_in |=> !ready_out && !status_out)
    else $error("flags kept without enable");
  chk_bus_hole: assert property (hole |-> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  // Main scenarios worth seeing at least once.
  cover property (tick && start_in ##1 status_out);
  cover property (tick && sensor_error);
  cover property (hole);
endmodule
`default_nettype wire

// File: testbench/asp_valve_model.sv
`timescale 1ns/10ps
`default_nettype none
module asp_valve_model
#(
  parameter logic [15:0] START_POS = 16'h1000
)
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst,
  // Drive in, stall request and transducer out.
  input  wire logic               stall,
  input  wire logic signed [15:0] valve_out,
  output logic             [15:0] actual_pos
);
  logic [2:0] div;

  // The axis creeps one count per eight clocks along the drive sign; a jammed
  // axis stands still so that the drive value can be judged exactly.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      div        <= 3'h0;
      actual_pos <= START_POS;
    end
    else
    begin
      div <= div + 3'h1;
      if (!stall && div == 3'h7 && valve_out != 16'sh0)
        actual_pos <= valve_out[15] ? actual_pos - 16'h1 : actual_pos + 16'h1;
    end
endmodule
`default_nettype wire

// File: testbench/tb_axis_sync_position_controller.sv
`timescale 1ns/10ps
`default_nettype none
module tb_axis_sync_position_controller;
  import asp_pkg::*;
  localparam int TK = 50;
  localparam logic [15:0] A = 16'h1000;
  // Bench-driven pins, all defined at time zero.
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b1;
  logic enable_in = 1'b0, start_in = 1'b0, sync_select_pin = 1'b0, sensor_error = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] command_pos = A, speed_demand = 16'h20, master_pos = A;
  // Block outputs and bookkeeping.
  logic [31:0] prdata, rv;
  logic pready, pslverr, ready_out, status_out, er;
  logic [15:0] actual_pos;
  logic signed [15:0] valve_out;
  int mismatches = 0, samples_checked = 0;

  always #4 clk = ~clk;

  asp_axis_ctrl #(.TICK_CYC(TK)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_in(enable_in), .start_in(start_in), .sync_select_pin(sync_select_pin),
    .sensor_error(sensor_error), .command_pos(command_pos), .speed_demand(speed_demand),
    .actual_pos(actual_pos), .master_pos(master_pos), .ready_out(ready_out),
    .status_out(status_out), .valve_out(valve_out));
  asp_valve_model PTR (.clk(clk), .rst(rst), .stall(stall), .valve_out(valve_out),
    .actual_pos(actual_pos));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; an idle cycle follows so back-to-back calls never clash.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  task automatic t_regs;
    apb(1'b0, ASP_OFS_BRAKE, 32'h0);
    chk("brake", rv, 32'h3E8);
    apb(1'b0, 8'h40, 32'h0);
    chk("hole err", {31'h0, er}, 32'h1);
  endtask

  task automatic t_enable;
    ticks(2);
    chk("ready", {31'h0, ready_out}, 32'h0);
    enable_in <= 1'b1;
    ticks(2);
    chk("ready", {31'h0, ready_out}, 32'h1);
    apb(1'b0, ASP_OFS_TARGET, 32'h0);
    chk("hold", {16'h0, rv[15:0]}, {16'h0, A});
  endtask

  // Every braking curve at an error of 0x100 and a distance of 0x64.
  task automatic t_curves;
    logic [7:0] ctl [3] = '{8'h11, 8'h13, 8'h15};
    logic [15:0] ex [3] = '{16'h64, 16'h12, 16'h1F};
    apb(1'b1, ASP_OFS_BRAKE, 32'h64);
    command_pos <= A + 16'h100;
    start_in <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, ASP_OFS_CTRL, {24'h0, ctl[i]});
      ticks(3);
      chk("curve", 32'(valve_out), {16'h0, ex[i]});
    end
    chk("status", {31'h0, status_out}, 32'h0);
    apb(1'b1, ASP_OFS_BRAKE, 32'hC8);
    apb(1'b1, ASP_OFS_CTRL, 32'h11);
    ticks(3);
    chk("gain", 32'(valve_out), 32'h32);
  endtask

  task automatic t_limit;
    apb(1'b1, ASP_OFS_BRAKE, 32'h64);
    apb(1'b1, ASP_OFS_SPEED, 32'h40);
    ticks(3);
    chk("limit", 32'(valve_out), 32'h40);
    apb(1'b1, ASP_OFS_CTRL, 32'h19);
    ticks(3);
    chk("demand", 32'(valve_out), 32'h20);
    apb(1'b1, ASP_OFS_SPEED, 32'h7FFF);
    apb(1'b1, ASP_OFS_CTRL, 32'h11);
    apb(1'b1, ASP_OFS_DEADB, 32'h200);
    ticks(3);
    chk("deadband", 32'(valve_out), 32'hC8);
    apb(1'b1, ASP_OFS_DEADB, 32'h0);
  endtask

  task automatic t_sync;
    sync_select_pin <= 1'b1;
    master_pos <= A + 16'h80;
    ticks(3);
    chk("sync", 32'(valve_out), 32'h32);
    chk("sync err", {31'h0, status_out}, 32'h0);
    master_pos <= A + 16'h4;
    ticks(3);
    chk("sync ok", {31'h0, status_out}, 32'h1);
    sync_select_pin <= 1'b0;
    ticks(3);
    chk("own", 32'(valve_out), 32'h64);
  endtask

  task automatic t_stop;
    command_pos <= A + 16'h4;
    ticks(3);
    chk("in_position_window", {31'h0, status_out}, 32'h1);
    start_in <= 1'b0;
    ticks(2);
    chk("no start", {31'h0, status_out}, 32'h0);
    command_pos <= A + 16'h100;
    start_in <= 1'b1;
    ticks(2);
    start_in <= 1'b0;
    ticks(2);
    apb(1'b0, ASP_OFS_TARGET, 32'h0);
    chk("stop", {16'h0, rv[15:0]}, {16'h0, A + 16'h20});
  endtask

  task automatic t_fault;
    apb(1'b1, ASP_OFS_EMERGENCY_OUTPUT_VALUE, 32'h123);
    enable_in <= 1'b0;
    ticks(3);
    chk("emergency_output_value", 32'(valve_out), 32'h123);
    apb(1'b1, ASP_OFS_CTRL, 32'h1);
    enable_in <= 1'b1;
    sensor_error <= 1'b1;
    ticks(3);
    chk("no emergency_output_value", 32'(valve_out), 32'h0);
    chk("ready", {31'h0, ready_out}, 32'h0);
    sensor_error <= 1'b0;
    ticks(2);
  endtask

  // Profile mode: the internal profile may advance by one speed limit per sample only.
  // The two reads sample exactly one tick period apart, so exactly one step lies between them.
  task automatic t_profile;
    logic [15:0] p0;
    apb(1'b1, ASP_OFS_SPEED, 32'h10);
    apb(1'b1, ASP_OFS_CTRL, 32'h10);
    command_pos <= A + 16'h100;
    start_in <= 1'b1;
    ticks(2);
    apb(1'b0, ASP_OFS_TARGET, 32'h0);
    p0 = rv[31:16];
    chk("profile target", {16'h0, rv[15:0]}, {16'h0, A + 16'h100});
    repeat (TK - 3) @(posedge clk);
    apb(1'b0, ASP_OFS_TARGET, 32'h0);
    chk("profile step", {16'h0, rv[31:16] - p0}, 32'h10);
    apb(1'b1, ASP_OFS_CTRL, 32'h1);
    apb(1'b1, ASP_OFS_SPEED, 32'h7FFF);
  endtask

  // The axis is free now, so the loop has to bring it into the window.
  task automatic t_move;
    int n;
    stall <= 1'b0;
    command_pos <= A + 16'h40;
    start_in <= 1'b1;
    ticks(2);
    n = 0;
    while (status_out !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    chk("reach", {31'h0, status_out}, 32'h1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Reset for eight cycles, then the scenarios in order.
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_enable;
    t_curves;
    t_limit;
    t_sync;
    t_stop;
    t_fault;
    t_profile;
    t_move;
    give_verdict;
  end

  // Cut a hung run short; the whole sequence needs far less than this.
  initial
  begin
    #(TK * 3200);
    mismatches++;
    give_verdict;
  end
endmodule

bind asp_axis_ctrl asp_axis_ctrl_chk #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .enable_in(enable_in), .start_in(start_in), .sensor_error(sensor_error), .ready_out(ready_out),
  .status_out(status_out), .valve_out(valve_out));
`default_nettype wire
